// ---- hdl/adc_flags_pkg.sv ----
// Constants shared by the converter result and status flag logic
`default_nettype none

package adc_flags_pkg;

  // Sizes
  localparam int NUM_CH = 8;
  localparam int RES_W  = 10;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_MODE     = 8'h04;
  localparam logic [7:0] OFS_CHAN_EN  = 8'h10;
  localparam logic [7:0] OFS_CHAN_DIS = 8'h14;
  localparam logic [7:0] OFS_CHAN_ST  = 8'h18;
  localparam logic [7:0] OFS_STATUS   = 8'h1c;
  localparam logic [7:0] OFS_LAST     = 8'h20;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h24;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h28;
  localparam logic [7:0] OFS_CH_RES   = 8'h30;

  // Field positions
  localparam int CTRL_START_BIT = 1;
  localparam int MODE_SLEEP_BIT = 0;
  localparam int STAT_DONE_LSB  = 0;
  localparam int STAT_OVR_LSB   = 8;
  localparam int STAT_FRESH_BIT = 16;
  localparam int STAT_GOVR_BIT  = 17;
  localparam int LAST_CH_LSB    = 16;
  localparam int IRQ_W          = 3;
  localparam int IRQ_EOC_BIT    = 0;
  localparam int IRQ_OVR_BIT    = 1;
  localparam int IRQ_GOVR_BIT   = 2;

  // Reset values
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;
  localparam logic             SLEEP_RST    = 1'b0;

  typedef enum logic [1:0] {
    SLP_AWAKE  = 2'b00,
    SLP_ARMED  = 2'b01,
    SLP_ASLEEP = 2'b10
  } sleepState_t;

endpackage : adc_flags_pkg

`default_nettype wire

// ---- hdl/channel_flag_bank.sv ----
// Per-channel conversion-done and overrun flags
`default_nettype none

module channel_flag_bank #(
  parameter int NUM_CH = adc_flags_pkg::NUM_CH
) (
  input  wire logic              clk_sys,
  input  wire logic              reset,
  input  wire logic [NUM_CH-1:0] storeVec,
  input  wire logic [NUM_CH-1:0] doneClr,
  input  wire logic              statusRead,
  output var  logic [NUM_CH-1:0] doneFlags,
  output var  logic [NUM_CH-1:0] ovrFlags,
  output logic                   ovrSetAny
);

  logic [NUM_CH-1:0] ovrSet;

  genvar i;
  generate
    for (i = 0; i < NUM_CH; i++) begin : g_ch
      assign ovrSet[i] = storeVec[i] & doneFlags[i];

      // done set by store, cleared by its reads
      always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
          doneFlags[i] <= 1'b0;
        end else if (storeVec[i]) begin
          doneFlags[i] <= 1'b1;
        end else if (doneClr[i]) begin
          doneFlags[i] <= 1'b0;
        end
      end

      always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
          ovrFlags[i] <= 1'b0;
        end else if (ovrSet[i]) begin
          ovrFlags[i] <= 1'b1;
        end else if (statusRead) begin
          ovrFlags[i] <= 1'b0;
        end
      end
    end
  endgenerate

  assign ovrSetAny = |ovrSet;

endmodule : channel_flag_bank

`default_nettype wire

// ---- hdl/sleep_sequencer.sv ----
// Deferred sleep entry of the converter
`default_nettype none

module sleep_sequencer (
  input  wire logic clk_sys,
  input  wire logic reset,
  input  wire logic sleepSel,
  input  wire logic startCmd,
  input  wire logic eocPulse,
  output var  logic sleepActive
);

  adc_flags_pkg::sleepState_t state_reg;
  adc_flags_pkg::sleepState_t state_next;

  // sleep only after the next conversion ends
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      adc_flags_pkg::SLP_AWAKE: begin
        if (sleepSel) state_next = adc_flags_pkg::SLP_ARMED;
      end
      adc_flags_pkg::SLP_ARMED: begin
        if (!sleepSel) state_next = adc_flags_pkg::SLP_AWAKE;
        else if (eocPulse) state_next = adc_flags_pkg::SLP_ASLEEP;
      end
      adc_flags_pkg::SLP_ASLEEP: begin
        if (!sleepSel) state_next = adc_flags_pkg::SLP_AWAKE;
        else if (startCmd) state_next = adc_flags_pkg::SLP_ARMED;
      end
      default: state_next = adc_flags_pkg::SLP_AWAKE;
    endcase
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state_reg   <= adc_flags_pkg::SLP_AWAKE;
      sleepActive <= 1'b0;
    end else begin
      state_reg   <= state_next;
      sleepActive <= (state_next == adc_flags_pkg::SLP_ASLEEP);
    end
  end

endmodule : sleep_sequencer

`default_nettype wire

// ---- hdl/adc_result_status_flags.sv ----
// Converter result registers, status flags, interrupt and sleep control
//
// Overview of operation
// - Only last-result read clears fresh flag
// - No fresh flag without stored data
// - Done already set still raises fresh
// - Store result in channel and last registers
// - Status read resets global overrun flag
// - Conversion during fresh flag sets global overrun
// - Other channel read cannot mask global overrun
// - Other channel disable cannot mask global overrun
// - Done still set gives channel overrun
// - Status read resets channel overrun flags
// - Channel or last read clears done
// - Disabled channel never raises done
// - Channel read clears only its done
// - Idle sleep request waits one conversion
//
// Added by the designer: the register addresses and the address-and-strobe port.
`default_nettype none

module adc_result_status_flags #(
  parameter int NUM_CH = adc_flags_pkg::NUM_CH,
  parameter int RES_W  = adc_flags_pkg::RES_W,
  parameter int CH_W   = $clog2(NUM_CH)
) (
  input  wire logic                             clk_sys,
  input  wire logic                             reset,
  input  wire logic [adc_flags_pkg::ADDR_W-1:0] regAddr,
  input  wire logic [adc_flags_pkg::DATA_W-1:0] regWrData,
  input  wire logic                             regWr,
  input  wire logic                             regRd,
  output var  logic [adc_flags_pkg::DATA_W-1:0] regRdData,
  input  wire logic                             eocPulse,
  input  wire logic [CH_W-1:0]                  eocChannel,
  input  wire logic [RES_W-1:0]                 eocData,
  output var  logic                             startConv,
  output var  logic [NUM_CH-1:0]                chanEnable,
  output logic                                  sleepActive,
  output var  logic                             irq
);

  localparam int AW = adc_flags_pkg::ADDR_W;
  localparam int DW = adc_flags_pkg::DATA_W;
  localparam int IW = adc_flags_pkg::IRQ_W;
  localparam logic [AW-1:0] RES_SPAN = AW'(4 * NUM_CH);

  // Stored results
  logic [RES_W-1:0]  chRes_reg [NUM_CH];
  logic [RES_W-1:0]  lastRes_reg;
  logic [CH_W-1:0]   lastCh_reg;

  // Global flags
  logic              fresh_reg;
  logic              govr_reg;
  logic              sleepSel_reg;
  logic [IW-1:0]     irqStat_reg;
  logic [IW-1:0]     irqStat_next;
  logic [IW-1:0]     irqMask_reg;

  // Per-channel flags from the bank
  logic [NUM_CH-1:0] doneFlags;
  logic [NUM_CH-1:0] ovrFlags;
  logic              ovrSetAny;

  // Decoded strobes
  logic              wrCtrl;
  logic              wrMode;
  logic              wrEn;
  logic              wrDis;
  logic              wrMask;
  logic              rdStat;
  logic              rdLast;
  logic              rdIrq;
  logic              rdRes;
  logic [AW-1:0]     resOff;
  logic              resHit;
  logic [CH_W-1:0]   resIdx;

  // Conversion events
  logic              chanLive;
  logic              storeEv;
  logic              govrSet;
  logic [NUM_CH-1:0] storeVec;
  logic [NUM_CH-1:0] doneClr;
  logic              startCmd;
  logic [DW-1:0]     rdNext;

  // Address decode
  always_comb begin
    wrCtrl = regWr && (regAddr == adc_flags_pkg::OFS_CTRL);
    wrMode = regWr && (regAddr == adc_flags_pkg::OFS_MODE);
    wrEn   = regWr && (regAddr == adc_flags_pkg::OFS_CHAN_EN);
    wrDis  = regWr && (regAddr == adc_flags_pkg::OFS_CHAN_DIS);
    wrMask = regWr && (regAddr == adc_flags_pkg::OFS_IRQ_MASK);
    rdStat = regRd && (regAddr == adc_flags_pkg::OFS_STATUS);
    rdLast = regRd && (regAddr == adc_flags_pkg::OFS_LAST);
    rdIrq  = regRd && (regAddr == adc_flags_pkg::OFS_IRQ_STAT);
    resOff = regAddr - adc_flags_pkg::OFS_CH_RES;
    resHit = (regAddr >= adc_flags_pkg::OFS_CH_RES)
             && (resOff < RES_SPAN) && (resOff[1:0] == 2'h0);
    resIdx = resOff[CH_W+1:2];
    rdRes  = regRd && resHit;
  end

  assign startCmd = wrCtrl && regWrData[adc_flags_pkg::CTRL_START_BIT];

  // a channel disabled before or at its end of conversion is dropped
  // such an event stores nothing and raises nothing
  // disabling another channel does not block this store
  always_comb begin
    chanLive = chanEnable[eocChannel];
    if (wrDis && regWrData[eocChannel]) begin
      chanLive = 1'b0;
    end
    storeEv = eocPulse && chanLive;
  end

  // global overrun on a store while fresh still set
  // reads of other channels do not enter this term
  assign govrSet = storeEv && fresh_reg;

  always_comb begin
    storeVec = '0;
    if (storeEv) begin
      storeVec[eocChannel] = 1'b1;
    end
  end

  // a channel read clears its own done bit only
  // last-result read clears done of the channel it holds
  always_comb begin
    doneClr = '0;
    if (rdRes) begin
      doneClr[resIdx] = 1'b1;
    end
    if (rdLast) begin
      doneClr[lastCh_reg] = 1'b1;
    end
  end

  channel_flag_bank #(
    .NUM_CH (NUM_CH)
  ) u_flags (
    .clk_sys    (clk_sys),
    .reset      (reset),
    .storeVec   (storeVec),
    .doneClr    (doneClr),
    .statusRead (rdStat),
    .doneFlags  (doneFlags),
    .ovrFlags   (ovrFlags),
    .ovrSetAny  (ovrSetAny)
  );

  // result goes to channel and last registers
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      for (int k = 0; k < NUM_CH; k++) begin
        chRes_reg[k] <= '0;
      end
      lastRes_reg <= '0;
      lastCh_reg  <= '0;
    end else if (storeEv) begin
      chRes_reg[eocChannel] <= eocData;
      lastRes_reg           <= eocData;
      lastCh_reg            <= eocChannel;
    end
  end

  // fresh set on every store, whatever done holds
  // cleared only by a last-result read
  // a store in the reading cycle keeps it set
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      fresh_reg <= 1'b0;
    end else if (storeEv) begin
      fresh_reg <= 1'b1;
    end else if (rdLast) begin
      fresh_reg <= 1'b0;
    end
  end

  // status read clears unless a new overrun arrives
  // the new overrun wins over the clear
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      govr_reg <= 1'b0;
    end else if (govrSet) begin
      govr_reg <= 1'b1;
    end else if (rdStat) begin
      govr_reg <= 1'b0;
    end
  end

  // Channel enables drive the conversion core directly
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      chanEnable <= '0;
    end else if (wrEn) begin
      chanEnable <= chanEnable | regWrData[NUM_CH-1:0];
    end else if (wrDis) begin
      chanEnable <= chanEnable & ~regWrData[NUM_CH-1:0];
    end
  end

  // Start is a single-cycle command to the core
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      startConv <= 1'b0;
    end else begin
      startConv <= startCmd;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      sleepSel_reg <= adc_flags_pkg::SLEEP_RST;
    end else if (wrMode) begin
      sleepSel_reg <= regWrData[adc_flags_pkg::MODE_SLEEP_BIT];
    end
  end

  // sleep waits for the next completed conversion
  // software arms sleep, then starts a conversion
  sleep_sequencer u_sleep (
    .clk_sys     (clk_sys),
    .reset       (reset),
    .sleepSel    (sleepSel_reg),
    .startCmd    (startCmd),
    .eocPulse    (eocPulse),
    .sleepActive (sleepActive)
  );

  // Sticky interrupt causes; a cause arriving with the read survives
  always_comb begin
    irqStat_next = irqStat_reg;
    if (rdIrq) begin
      irqStat_next = '0;
    end
    irqStat_next[adc_flags_pkg::IRQ_EOC_BIT] =
      irqStat_next[adc_flags_pkg::IRQ_EOC_BIT] | storeEv;
    irqStat_next[adc_flags_pkg::IRQ_OVR_BIT] =
      irqStat_next[adc_flags_pkg::IRQ_OVR_BIT] | ovrSetAny;
    irqStat_next[adc_flags_pkg::IRQ_GOVR_BIT] =
      irqStat_next[adc_flags_pkg::IRQ_GOVR_BIT] | govrSet;
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      irqStat_reg <= '0;
    end else begin
      irqStat_reg <= irqStat_next;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      irqMask_reg <= adc_flags_pkg::IRQ_MASK_RST;
    end else if (wrMask) begin
      irqMask_reg <= regWrData[IW-1:0];
    end
  end

  // Output is registered, so it trails the sticky bit by nothing
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irqStat_next & irqMask_reg);
    end
  end

  // Read mux shows pre-clear values; unmapped addresses read zero
  always_comb begin
    rdNext = '0;
    case (regAddr)
      adc_flags_pkg::OFS_MODE: begin
        rdNext[adc_flags_pkg::MODE_SLEEP_BIT] = sleepSel_reg;
      end
      adc_flags_pkg::OFS_CHAN_ST: begin
        rdNext[NUM_CH-1:0] = chanEnable;
      end
      adc_flags_pkg::OFS_STATUS: begin
        rdNext[adc_flags_pkg::STAT_DONE_LSB +: NUM_CH] = doneFlags;
        rdNext[adc_flags_pkg::STAT_OVR_LSB +: NUM_CH]  = ovrFlags;
        rdNext[adc_flags_pkg::STAT_FRESH_BIT] = fresh_reg;
        rdNext[adc_flags_pkg::STAT_GOVR_BIT]  = govr_reg;
      end
      adc_flags_pkg::OFS_LAST: begin
        rdNext[RES_W-1:0] = lastRes_reg;
        rdNext[adc_flags_pkg::LAST_CH_LSB +: CH_W] = lastCh_reg;
      end
      adc_flags_pkg::OFS_IRQ_STAT: begin
        rdNext[IW-1:0] = irqStat_reg;
      end
      adc_flags_pkg::OFS_IRQ_MASK: begin
        rdNext[IW-1:0] = irqMask_reg;
      end
      default: begin
        if (resHit) begin
          rdNext[RES_W-1:0] = chRes_reg[resIdx];
        end
      end
    endcase
  end

  // Data stand only in the cycle after the read strobe
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      regRdData <= '0;
    end else if (regRd) begin
      regRdData <= rdNext;
    end else begin
      regRdData <= '0;
    end
  end

endmodule : adc_result_status_flags

`default_nettype wire

// ---- verification/adc_result_status_flags_props.sv ----
// Checker of the result and status flag behaviour
`default_nettype none
module adc_result_status_flags_props #(
  parameter int NUM_CH = 8,
  parameter int RES_W  = 10,
  parameter int CH_W   = 3
) (
  input wire logic              clk_sys,
  input wire logic              reset,
  input wire logic [7:0]        regAddr,
  input wire logic [31:0]       regWrData,
  input wire logic              regWr,
  input wire logic              regRd,
  input wire logic [31:0]       regRdData,
  input wire logic              eocPulse,
  input wire logic [CH_W-1:0]   eocChannel,
  input wire logic [RES_W-1:0]  eocData,
  input wire logic              startConv,
  input wire logic [NUM_CH-1:0] chanEnable,
  input wire logic              sleepActive,
  input wire logic              irq
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       statRd;
  logic       lastRd;
  logic       resRd;
  logic [7:0] resOfs;
  assign resOfs = regAddr - adc_flags_pkg::OFS_CH_RES;
  assign statRd = regRd && regAddr == adc_flags_pkg::OFS_STATUS;
  assign lastRd = regRd && regAddr == adc_flags_pkg::OFS_LAST;
  assign resRd  = regRd && resOfs < 8'h20 && resOfs[1:0] == 2'h0;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  chk_done_clear: assert property (
    (resRd && !eocPulse) ##1 !eocPulse ##1 (statRd && !eocPulse)
    |=> regRdData[$past(resOfs[4:2], 3)] == 1'b0)
    else $error("done flag kept after result read");
  chk_fresh_clear: assert property (
    (lastRd && !eocPulse) ##1 !eocPulse ##1 (statRd && !eocPulse)
    |=> !regRdData[16]) else $error("fresh flag kept after last read");
  chk_fresh_keep: assert property (
    (statRd && !eocPulse) ##1 (!eocPulse && !lastRd) ##1
    (resRd && !eocPulse) ##1 (!eocPulse && !lastRd) ##1
    (statRd && !eocPulse)
    |=> regRdData[16] == $past(regRdData[16], 4))
    else $error("fresh flag changed by result read");
  chk_ovr_clear: assert property (
    (statRd && !eocPulse) ##1 !eocPulse ##1 (statRd && !eocPulse)
    |=> !regRdData[17] && regRdData[15:8] == 8'h00)
    else $error("overrun kept after status read");
  chk_no_ghost: assert property (
    eocPulse && !chanEnable[eocChannel] && !regWr && !$past(regWr)
    && !irq |=> !irq) else $error("disabled channel raised interrupt");
  chk_store_last: assert property (
    (eocPulse && chanEnable[eocChannel] && !regWr) ##1 !eocPulse ##1
    (lastRd && !eocPulse) |=> regRdData[18:0] ==
    {$past(eocChannel, 3), 6'h00, $past(eocData, 3)})
    else $error("last result not stored");
  chk_sleep_eoc: assert property (
    $rose(sleepActive) |-> $past(eocPulse))
    else $error("sleep entered without conversion end");
  chk_irq_clear: assert property (
    regRd && regAddr == adc_flags_pkg::OFS_IRQ_STAT && !eocPulse |=> !irq)
    else $error("interrupt kept after status read");
  cov_coll: cover property (statRd && eocPulse);
  cov_sleep: cover property ($rose(sleepActive));
  cov_irq: cover property ($rose(irq));
endmodule : adc_result_status_flags_props
bind adc_result_status_flags adc_result_status_flags_props #(
  .NUM_CH(NUM_CH), .RES_W(RES_W), .CH_W(CH_W)) u_props (
  .clk_sys(clk_sys), .reset(reset), .regAddr(regAddr),
  .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
  .regRdData(regRdData), .eocPulse(eocPulse), .eocChannel(eocChannel),
  .eocData(eocData), .startConv(startConv), .chanEnable(chanEnable),
  .sleepActive(sleepActive), .irq(irq));
`default_nettype wire

// ---- verification/adc_core_model.sv ----
// Behavioural model of the analog conversion core
`default_nettype none
module adc_core_model (
  input  wire logic       clk_sys,
  input  wire logic       reset,
  input  wire logic       startConv,
  input  wire logic       fireReq,
  input  wire logic [2:0] fireCh,
  output logic            eocPulse,
  output logic [2:0]      eocChannel,
  output logic [9:0]      eocData
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] runCnt;
  logic [9:0] junk;
  logic       runEoc;
  // Started conversion ends on channel 1 a few cycles later
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) runCnt <= 3'h0;
    else if (startConv) runCnt <= 3'h3;
    else if (runCnt != 3'h0) runCnt <= runCnt - 3'h1;
  end
  // Lines carry a toggling pattern outside a conversion end
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) junk <= 10'h155;
    else junk <= ~junk;
  end
  assign runEoc = runCnt == 3'h1;
  assign eocPulse = fireReq | runEoc;
  assign eocChannel = fireReq ? fireCh : (runEoc ? 3'h1 : junk[2:0]);
  assign eocData = eocPulse ? {7'h2a, eocChannel} : junk;
endmodule : adc_core_model
`default_nettype wire

// ---- verification/tb_adc_result_status_flags.sv ----
// Self-checking bench of the converter result and status flags
`default_nettype none
`define CHK(nm, ex, got) \
  comparisons++; \
  if ((got) !== (ex)) begin \
    miscompares++; \
    $display("ERROR %s exp %h got %h", nm, ex, got); \
  end
module tb_adc_result_status_flags;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys = 1'b0;
  logic        reset = 1'b1;
  logic [7:0]  regAddr = 8'h00;
  logic [31:0] regWrData = 32'h0;
  logic        regWr = 1'b0;
  logic        regRd = 1'b0;
  logic        fireReq = 1'b0;
  logic [2:0]  fireCh = 3'h0;
  logic [31:0] regRdData;
  logic [31:0] q;
  logic        eocPulse;
  logic [2:0]  eocChannel;
  logic [9:0]  eocData;
  logic        startConv;
  logic [7:0]  chanEnable;
  logic        sleepActive;
  logic        irq;
  int          miscompares = 0;
  int          comparisons = 0;
  adc_result_status_flags u_dut (
    .clk_sys(clk_sys), .reset(reset), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .eocPulse(eocPulse), .eocChannel(eocChannel),
    .eocData(eocData), .startConv(startConv), .chanEnable(chanEnable),
    .sleepActive(sleepActive), .irq(irq));
  adc_core_model u_core (
    .clk_sys(clk_sys), .reset(reset), .startConv(startConv),
    .fireReq(fireReq), .fireCh(fireCh), .eocPulse(eocPulse),
    .eocChannel(eocChannel), .eocData(eocData));
  always #25 clk_sys = ~clk_sys;
  task automatic summarize();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : summarize
  // One bus access, optionally with a conversion end in the same cycle
  task automatic bus(input logic w, input logic r, input logic [7:0] a,
                     input logic [31:0] d, input logic f,
                     input logic [2:0] c);
    @(posedge clk_sys);
    regWr <= w;
    regRd <= r;
    regAddr <= a;
    regWrData <= d;
    fireReq <= f;
    fireCh <= c;
    @(posedge clk_sys);
    regWr <= 1'b0;
    regRd <= 1'b0;
    fireReq <= 1'b0;
    @(negedge clk_sys);
    q = regRdData;
  endtask : bus
  task automatic rd(input logic [7:0] a);
    bus(1'b0, 1'b1, a, 32'h0, 1'b0, 3'h0);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, 1'b0, a, d, 1'b0, 3'h0);
  endtask : wr
  task automatic eo(input logic [2:0] c);
    bus(1'b0, 1'b0, 8'h00, 32'h0, 1'b1, c);
  endtask : eo
  function automatic logic [7:0] res(input logic [2:0] c);
    return adc_flags_pkg::OFS_CH_RES + {3'h0, c, 2'h0};
  endfunction : res
  function automatic logic [31:0] lastVal(input logic [2:0] c);
    return {13'h0, c, 6'h00, 7'h2a, c};
  endfunction : lastVal
  task automatic st(input logic [31:0] e);
    rd(adc_flags_pkg::OFS_STATUS);
    `CHK("status", e, q)
  endtask : st
  task automatic lt(input logic [2:0] c);
    rd(adc_flags_pkg::OFS_LAST);
    `CHK("last", lastVal(c), q)
  endtask : lt
  task automatic t_reset();
    st(32'h0);
    rd(adc_flags_pkg::OFS_IRQ_MASK);
    `CHK("mask", 32'h0, q)
    rd(8'hfc);
    `CHK("unmapped", 32'h0, q)
    wr(adc_flags_pkg::OFS_CHAN_EN, 32'h0f);
    `CHK("enables", 8'h0f, chanEnable)
  endtask : t_reset
  task automatic t_fresh();
    eo(3'h2);
    st(32'h00010004);
    rd(res(3'h2));
    `CHK("result", {22'h0, 7'h2a, 3'h2}, q)
    st(32'h00010000);
    lt(3'h2);
    st(32'h0);
  endtask : t_fresh
  task automatic t_over();
    eo(3'h0);
    eo(3'h0);
    lt(3'h0);
    bus(1'b0, 1'b1, adc_flags_pkg::OFS_STATUS, 32'h0, 1'b1, 3'h0);
    `CHK("status", 32'h00020100, q)
    st(32'h00010001);
    bus(1'b0, 1'b1, adc_flags_pkg::OFS_STATUS, 32'h0, 1'b1, 3'h1);
    st(32'h00030003);
    st(32'h00010003);
    lt(3'h1);
    rd(res(3'h0));
    st(32'h0);
  endtask : t_over
  task automatic t_coll();
    eo(3'h3);
    eo(3'h2);
    lt(3'h2);
    st(32'h00020008);
    bus(1'b0, 1'b1, res(3'h0), 32'h0, 1'b1, 3'h3);
    st(32'h00010808);
    bus(1'b0, 1'b1, res(3'h2), 32'h0, 1'b1, 3'h3);
    st(32'h00030808);
    lt(3'h3);
    st(32'h0);
  endtask : t_coll
  task automatic t_dis();
    eo(3'h1);
    bus(1'b0, 1'b1, adc_flags_pkg::OFS_LAST, 32'h0, 1'b1, 3'h5);
    `CHK("last", lastVal(3'h1), q)
    st(32'h0);
    bus(1'b0, 1'b1, res(3'h0), 32'h0, 1'b1, 3'h5);
    st(32'h0);
  endtask : t_dis
  task automatic t_disable();
    bus(1'b1, 1'b0, adc_flags_pkg::OFS_CHAN_DIS, 32'h8, 1'b1, 3'h1);
    bus(1'b1, 1'b0, adc_flags_pkg::OFS_CHAN_DIS, 32'h1, 1'b1, 3'h1);
    st(32'h00030202);
    `CHK("enables", 8'h06, chanEnable)
    lt(3'h1);
    st(32'h0);
  endtask : t_disable
  task automatic t_irq();
    rd(adc_flags_pkg::OFS_IRQ_STAT);
    wr(adc_flags_pkg::OFS_IRQ_MASK, 32'h1);
    eo(3'h1);
    `CHK("irq", 1'b1, irq)
    rd(adc_flags_pkg::OFS_IRQ_STAT);
    `CHK("irq status", 32'h1, q)
    `CHK("irq", 1'b0, irq)
    lt(3'h1);
    wr(adc_flags_pkg::OFS_IRQ_MASK, 32'h2);
    eo(3'h1);
    `CHK("irq", 1'b0, irq)
    rd(adc_flags_pkg::OFS_IRQ_STAT);
    `CHK("irq status", 32'h1, q)
    lt(3'h1);
  endtask : t_irq
  task automatic t_sleep();
    int n;
    wr(adc_flags_pkg::OFS_MODE, 32'h1);
    repeat (5) @(negedge clk_sys);
    `CHK("sleep", 1'b0, sleepActive)
    wr(adc_flags_pkg::OFS_CTRL, 32'h2);
    `CHK("start", 1'b1, startConv)
    for (n = 0; n < 20 && sleepActive !== 1'b1; n++) @(negedge clk_sys);
    `CHK("sleep", 1'b1, sleepActive)
    lt(3'h1);
    wr(adc_flags_pkg::OFS_CTRL, 32'h2);
    `CHK("sleep", 1'b0, sleepActive)
    for (n = 0; n < 20 && sleepActive !== 1'b1; n++) @(negedge clk_sys);
    `CHK("sleep", 1'b1, sleepActive)
    lt(3'h1);
    wr(adc_flags_pkg::OFS_MODE, 32'h0);
    repeat (2) @(negedge clk_sys);
    `CHK("sleep", 1'b0, sleepActive)
  endtask : t_sleep
  initial begin
    repeat (8) @(posedge clk_sys);
    reset <= 1'b0;
    t_reset();
    t_fresh();
    t_over();
    t_coll();
    t_dis();
    t_disable();
    t_irq();
    t_sleep();
    summarize();
  end
  // Whole sequence needs well under two hundred cycles
  initial begin
    repeat (5000) @(posedge clk_sys);
    miscompares++;
    summarize();
  end
endmodule : tb_adc_result_status_flags
`default_nettype wire
